// ===== adr_consts.svh
`ifndef ADR_CONSTS_SVH
`define ADR_CONSTS_SVH

// Register offsets on the control bus.
`define ADR_OFF_RSVD_PRE      8'h3C
`define ADR_OFF_BLOCK_SEL     8'h3D
`define ADR_OFF_INSTR_CTRL    8'h3E
`define ADR_OFF_RSVD_LO       8'h3F
`define ADR_OFF_RSVD_HI       8'h4F
`define ADR_OFF_DMIC_POL      8'h50
`define ADR_OFF_DIG_SETUP     8'h51

// Reset values.
`define ADR_RST_RSVD_PRE      8'h00
`define ADR_RST_BLOCK_SEL     5'h01
`define ADR_RST_INSTR_CTRL    8'h00
`define ADR_RST_DMIC_POL      2'h0
`define ADR_RST_DIG_SETUP     8'h00

// Field positions.
`define ADR_SEL_W             5
`define ADR_SEL_PROGRAMMABLE  5'h00
`define ADR_SEL_LAST_CHAIN    5'h12
`define ADR_SEL_UNITY_LAST    5'h06
`define ADR_BIT_AUX_A         6
`define ADR_BIT_AUX_B         5
`define ADR_BIT_CTR_HOLD      4
`define ADR_BIT_POWER         6
`define ADR_BIT_ROUTE         4
`define ADR_BIT_MIC_EN        2

// Volume soft-step codes.
`define ADR_STEP_EVERY        2'h0
`define ADR_STEP_EVERY_OTHER  2'h1
`define ADR_STEP_JUMP         2'h2

// Oversampling ratio at which the default comb-integrator gain is unity.
`define ADR_OSR_UNITY         8'h40

// Control bus receive bit count.
`define ADR_BITS_PER_BYTE     4'h8

`endif

// ===== adr_host.sv
// Control bus host; the data pin is open drain with a pull-up, the clock pin is driven both high and low.
////////////////////////////////////////
module adr_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic i_clock,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  // Six cycles a phase leaves margin over the device's pin synchronisers.
  task automatic ph();
    repeat (6) @(negedge i_clock);
  endtask : ph
  task automatic bit_io(input logic b, output logic q);
    o_sda_low = !b;
    ph();
    o_scl = 1'h1;
    ph();
    q = i_sda_line;
    o_scl = 1'h0;
  endtask : bit_io
  task automatic start();
    o_sda_low = 1'h0;
    ph();
    o_scl = 1'h1;
    ph();
    o_sda_low = 1'h1;
    ph();
    o_scl = 1'h0;
  endtask : start
  task automatic stop();
    o_sda_low = 1'h1;
    ph();
    o_scl = 1'h1;
    ph();
    o_sda_low = 1'h0;
    ph();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask : xfer
  // Undefined select codes and reserved places are never written.
  task automatic wr(input logic [7:0] off, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    ok = !(off == 8'h3C || (off > 8'h3E && off < 8'h50) || (off == 8'h3D && d > 8'h12));
    if (ok) begin
      start();
      xfer({DEV_ADDR, 1'h0}, 1'h1, q, a[0]);
      xfer(off, 1'h1, q, a[1]);
      xfer(d, 1'h1, q, a[2]);
      stop();
      ok = (a == 3'h0);
    end
  endtask : wr
  task automatic rd(input logic [7:0] off, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] a;
    start();
    xfer({DEV_ADDR, 1'h0}, 1'h1, q, a[0]);
    xfer(off, 1'h1, q, a[1]);
    start();
    xfer({DEV_ADDR, 1'h1}, 1'h1, q, a[2]);
    xfer(8'hFF, 1'h1, d, a[3]);
    stop();
    ok = (a[2:0] == 3'h0);
  endtask : rd
endmodule : adr_host

// ===== adr_pkg.sv
`include "adr_consts.svh"

package adr_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } adr_state_e;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_REG  = 3'h2,
    PH_DATA = 3'h4
  } adr_phase_e;

  typedef struct packed {
    logic [2:0]           scl_s;
    logic [2:0]           sda_s;
    logic [2:0]           mod_s;
    logic [1:0]           din_s;
    logic [1:0]           cin_s;
    adr_state_e           state;
    adr_phase_e           phase;
    logic [3:0]           cnt;
    logic [7:0]           shift;
    logic                 rw;
    logic [7:0]           ptr;
    logic                 sda_oe;
    logic [7:0]           rsvd_pre;
    logic [`ADR_SEL_W-1:0] sel;
    logic                 aux_a;
    logic                 aux_b;
    logic                 ctr_hold;
    logic [1:0]           pol;
    logic [7:0]           dig;
    logic                 instr_mode;
    logic [`ADR_SEL_W-1:0] chain;
    logic                 frame_rst_en;
    logic                 cic_unity;
    logic [1:0]           mic_bit;
    logic [1:0]           mic_vld;
  } adr_top_s;

  typedef struct packed {
    logic [6:0] gain;
    logic       half;
  } adr_step_s;

endpackage : adr_pkg

// ===== adr_regs.sv
// Notes on behaviour
// - Select code zero runs the programmable instruction mode.
// - Codes one to eighteen pick chains; reset one.
// - Aux bit A feeds engine conditional jumps.
// - Aux bit B feeds engine conditional jumps.
// - Bit four clear resets counter each frame.
// - Left mic capture edge follows polarity bit one.
// - Right mic capture edge follows polarity bit zero.
// - Bit seven powers the left channel up.
// - Bit six powers the right channel up.
// - Bit five picks left mic source pin.
// - Bit four picks right mic source pin.
// - Bit three enables left digital microphone path.
// - Bit two enables right digital microphone path.
// - Soft-step code sets volume step rate.
// - Ratio 64 with chains one-six: default unity.
`include "adr_consts.svh"

module adr_regs
  import adr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary bus address.
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_mod_clock,
  input  wire logic       i_mic_data_pin,
  input  wire logic       i_mic_clock_pin,
  input  wire logic [7:0] i_converter_oversample_ratio,
  input  wire logic       i_sample_tick,
  input  wire logic [6:0] i_left_volume_target,
  input  wire logic [6:0] i_right_volume_target,
  output logic            o_instruction_mode,
  output logic [4:0]      o_chain_select,
  output logic            o_aux_cond_a,
  output logic            o_aux_cond_b,
  output logic            o_frame_counter_reset_en,
  output logic            o_left_power_up,
  output logic            o_right_power_up,
  output logic            o_left_mic_enable,
  output logic            o_right_mic_enable,
  output logic            o_cic_default_unity,
  output logic            o_left_mic_bit,
  output logic            o_left_mic_valid,
  output logic            o_right_mic_bit,
  output logic            o_right_mic_valid,
  output logic [6:0]      o_left_gain,
  output logic [6:0]      o_right_gain
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and edge detection.

  adr_top_s   q;
  adr_top_s   n;
  logic       sda_in;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       mod_rise;
  logic       mod_fall;
  logic [7:0] rdata;

  // Only the second and third synchroniser stages are looked at.
  // A start or a stop is a data change seen while the clock is high on both stages.
  assign sda_in    = q.sda_s[1];
  assign scl_rise  = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall  = ~q.scl_s[1] & q.scl_s[2];
  assign bus_start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
  assign bus_stop  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];
  assign mod_rise  = q.mod_s[1] & ~q.mod_s[2];
  assign mod_fall  = ~q.mod_s[1] & q.mod_s[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Read map.
  // The reserved block and unmapped offsets read as zero, as do the unused upper bits of each
  // register, so the host never sees stale shift data there.

  always_comb begin
    rdata = 8'h00;
    case (q.ptr)
      `ADR_OFF_RSVD_PRE:   rdata = q.rsvd_pre;
      `ADR_OFF_BLOCK_SEL:  rdata = {3'h0, q.sel};
      `ADR_OFF_INSTR_CTRL: rdata = {1'b0, q.aux_a, q.aux_b, q.ctr_hold, 4'h0};
      `ADR_OFF_DMIC_POL:   rdata = {6'h00, q.pol};
      `ADR_OFF_DIG_SETUP:  rdata = q.dig;
      default:             rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    // Everything holds unless a branch below moves it.
    n = q;
    // Every pin input passes two flip-flops before any logic below reads it.
    n.scl_s = {q.scl_s[1:0], i_scl};
    n.sda_s = {q.sda_s[1:0], i_sda};
    n.mod_s = {q.mod_s[1:0], i_mod_clock};
    n.din_s = {q.din_s[0], i_mic_data_pin};
    n.cin_s = {q.cin_s[0], i_mic_clock_pin};

    // Control bus slave. A stop or a repeated start aborts any byte in flight.
    if (bus_stop) begin
      n.state  = ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (bus_start) begin
      n.state  = ST_RX;
      n.phase  = PH_ADDR;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      case (q.state)
        // Nothing is driven until a start addresses the block.
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        // Bits are taken on the synchronised clock rise. The byte is acted on at the fall after
        // bit eight, so the acknowledge never overlaps a bit the host still holds.
        ST_RX: begin
          if (scl_rise && (q.cnt != `ADR_BITS_PER_BYTE)) begin
            n.shift = {q.shift[6:0], sda_in};
            n.cnt   = q.cnt + 4'h1;
          end else if (scl_fall && (q.cnt == `ADR_BITS_PER_BYTE)) begin
            if ((q.phase == PH_ADDR) && (q.shift[7:1] != DEV_ADDR)) begin
              // Another address: stay off the line until the next start.
              n.state = ST_IDLE;
            end else begin
              n.sda_oe = 1'b1;
              n.state  = ST_ACK;
              case (q.phase)
                PH_ADDR: n.rw  = q.shift[0];
                PH_REG:  n.ptr = q.shift;
                default: begin
                  // Writes to the reserved block and to unmapped offsets are dropped.
                  case (q.ptr)
                    `ADR_OFF_RSVD_PRE:   n.rsvd_pre = q.shift;
                    `ADR_OFF_BLOCK_SEL:  n.sel = q.shift[`ADR_SEL_W-1:0];
                    `ADR_OFF_INSTR_CTRL: begin
                      n.aux_a    = q.shift[`ADR_BIT_AUX_A];
                      n.aux_b    = q.shift[`ADR_BIT_AUX_B];
                      n.ctr_hold = q.shift[`ADR_BIT_CTR_HOLD];
                    end
                    `ADR_OFF_DMIC_POL:   n.pol = q.shift[1:0];
                    `ADR_OFF_DIG_SETUP:  n.dig = q.shift;
                    default:             n.rsvd_pre = q.rsvd_pre;
                  endcase
                  // The pointer moves on after every data byte, so a burst walks the map.
                  n.ptr = q.ptr + 8'h01;
                end
              endcase
            end
          end
        end
        // The acknowledge stands until the next clock fall; a read address turns the bus round here.
        ST_ACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if ((q.phase == PH_ADDR) && q.rw) begin
              n.state  = ST_TX;
              n.shift  = rdata;
              n.sda_oe = ~rdata[7];
            end else begin
              // A write goes on to the pointer byte, then to data bytes.
              n.state  = ST_RX;
              n.sda_oe = 1'b0;
              n.phase  = (q.phase == PH_ADDR) ? PH_REG : PH_DATA;
            end
          end
        end
        // Each bit is launched a few cycles after the clock falls, well inside the host's low phase.
        ST_TX: begin
          if (scl_rise) begin
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == `ADR_BITS_PER_BYTE) begin
              // Let go of the line for the host's acknowledge bit.
              n.sda_oe = 1'b0;
              n.state  = ST_RACK;
              n.ptr    = q.ptr + 8'h01;
            end else begin
              n.shift  = {q.shift[6:0], 1'b0};
              n.sda_oe = ~q.shift[6];
            end
          end
        end
        // A released line on the ninth rise ends the read; a low line asks for the next byte.
        ST_RACK: begin
          if (scl_rise && sda_in) begin
            n.state = ST_IDLE;
          end else if (scl_fall) begin
            n.state  = ST_TX;
            n.cnt    = 4'h0;
            n.shift  = rdata;
            n.sda_oe = ~rdata[7];
          end
        end
        default: begin
          n.state  = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Engine controls, decoded from the current register contents.
    // They are registered once more, so each trails its register field by one clock.
    n.instr_mode   = (q.sel == `ADR_SEL_PROGRAMMABLE);
    n.chain        = q.sel;
    n.frame_rst_en = ~q.ctr_hold;
    n.cic_unity    = (i_converter_oversample_ratio == `ADR_OSR_UNITY) &&
                     (q.sel != `ADR_SEL_PROGRAMMABLE) && (q.sel <= `ADR_SEL_UNITY_LAST);

    // Microphone capture; index 1 is the left channel, index 0 the right.
    // Power gates capture as well as enable, so a channel that is off never raises valid.
    for (int ch = 0; ch < 2; ch++) begin
      n.mic_vld[ch] = 1'b0;
      if (q.dig[`ADR_BIT_POWER + ch] && q.dig[`ADR_BIT_MIC_EN + ch] &&
          (q.pol[ch] ? mod_fall : mod_rise)) begin
        n.mic_bit[ch] = q.dig[`ADR_BIT_ROUTE + ch] ? q.cin_s[1] : q.din_s[1];
        n.mic_vld[ch] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // The asynchronous reset loads constants only; every field takes its next value each edge.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q              <= '0;
      // The bus synchronisers start at the idle-high level, so release never looks like a start.
      q.scl_s        <= 3'h7;
      q.sda_s        <= 3'h7;
      q.state        <= ST_IDLE;
      q.phase        <= PH_ADDR;
      q.rsvd_pre     <= `ADR_RST_RSVD_PRE;
      q.sel          <= `ADR_RST_BLOCK_SEL;
      q.pol          <= `ADR_RST_DMIC_POL;
      q.dig          <= `ADR_RST_DIG_SETUP;
      q.chain        <= `ADR_RST_BLOCK_SEL;
      q.frame_rst_en <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Volume soft-stepping per channel.

  logic [1:0][6:0] vol_target;
  logic [1:0][6:0] vol_gain;

  // Both channels share the tick and the rate field; each follows its own target.
  assign vol_target = {i_left_volume_target, i_right_volume_target};

  for (genvar ch = 0; ch < 2; ch++) begin : g_step
    adr_soft_step #(
      .WIDTH (7)
    ) u_step (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_target  (vol_target[ch]),
      .i_tick    (i_sample_tick),
      .i_mode    (q.dig[1:0]),
      .o_gain    (vol_gain[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The data pin is open drain: only the enable moves and the driven value stays low.
  assign o_sda                    = 1'b0;
  assign o_sda_oe                 = q.sda_oe;
  assign o_instruction_mode       = q.instr_mode;
  assign o_chain_select           = q.chain;
  assign o_aux_cond_a             = q.aux_a;
  assign o_aux_cond_b             = q.aux_b;
  assign o_frame_counter_reset_en = q.frame_rst_en;
  assign o_left_power_up          = q.dig[`ADR_BIT_POWER + 1];
  assign o_right_power_up         = q.dig[`ADR_BIT_POWER];
  assign o_left_mic_enable        = q.dig[`ADR_BIT_MIC_EN + 1];
  assign o_right_mic_enable       = q.dig[`ADR_BIT_MIC_EN];
  assign o_cic_default_unity      = q.cic_unity;
  assign o_left_mic_bit           = q.mic_bit[1];
  assign o_left_mic_valid         = q.mic_vld[1];
  assign o_right_mic_bit          = q.mic_bit[0];
  assign o_right_mic_valid        = q.mic_vld[0];
  assign o_left_gain              = vol_gain[1];
  assign o_right_gain             = vol_gain[0];

endmodule : adr_regs

// ===== adr_regs_sva.sv
// Port-level checker for the converter control registers.
////////////////////////////////////////
module adr_regs_sva (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       i_scl,
  input wire logic [7:0] i_converter_oversample_ratio,
  input wire logic       i_sample_tick,
  input wire logic [6:0] i_left_volume_target,
  input wire logic       o_instruction_mode,
  input wire logic [4:0] o_chain_select,
  input wire logic       o_aux_cond_a,
  input wire logic       o_frame_counter_reset_en,
  input wire logic       o_left_power_up,
  input wire logic       o_left_mic_enable,
  input wire logic       o_left_mic_valid,
  input wire logic       o_right_mic_valid,
  input wire logic       o_cic_default_unity,
  input wire logic [6:0] o_left_gain
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  a_reset_state: assert property ($rose(i_reset_n) |->
    o_chain_select == 5'h01 && o_frame_counter_reset_en)
    else $error("state after reset wrong");
  a_mode_sel: assert property (o_instruction_mode == (o_chain_select == 5'h00))
    else $error("instruction mode disagrees with select");
  // Only judged while the select is steady; the flag is registered with the select and trails the ratio input by a cycle.
  a_unity_flag: assert property ($past(i_reset_n) && $stable(o_chain_select) |->
    o_cic_default_unity == ($past(i_converter_oversample_ratio) == 8'h40 && o_chain_select inside {[5'h01:5'h06]}))
    else $error("unity flag wrong");
  // Valid is decided from the setup one clock before it shows, so the gate is judged there.
  a_left_gated: assert property (o_left_mic_valid |-> $past(o_left_power_up && o_left_mic_enable))
    else $error("left capture while off");
  a_left_pulse: assert property (o_left_mic_valid |=> !o_left_mic_valid)
    else $error("left capture longer than a cycle");
  a_right_pulse: assert property (o_right_mic_valid |=> !o_right_mic_valid)
    else $error("right capture longer than a cycle");
  a_gain_cause: assert property ($past(i_reset_n, 2) && !$stable(o_left_gain) |->
    $past(i_sample_tick) || o_left_gain == $past(i_left_volume_target))
    else $error("gain moved without tick");
  a_aux_bus: assert property ($past(i_reset_n) &&
    (!$stable(o_aux_cond_a) || !$stable(o_frame_counter_reset_en)) |-> !i_scl)
    else $error("control bit changed outside a bus write");
  c_prog_mode: cover property (o_instruction_mode);
  c_left_capture: cover property (o_left_mic_valid);
  c_unity: cover property (o_cic_default_unity);
endmodule : adr_regs_sva

// ===== adr_regs_tb_top.sv
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module adr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clock = 1'h0, i_reset_n = 1'h0, tick = 1'h0, mod_clk = 1'h0, mdat = 1'h0, mclk = 1'h0;
  logic [7:0] ratio = 8'h00;
  logic [6:0] tgt_l = 7'h00, tgt_r = 7'h00, gain_l, gain_r;
  logic       scl, host_low, sda_o, oe, instr, aux_a, aux_b, frame_en, unity;
  logic       pwr_l, pwr_r, en_l, en_r, bit_l, val_l, bit_r, val_r;
  logic [4:0] chain;
  int         failures = 0, n_compared = 0, n_ticks = 0;
  wire        sda_line = !(host_low || (oe && !sda_o));
  adr_regs DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_o),
    .o_sda_oe(oe), .i_mod_clock(mod_clk), .i_mic_data_pin(mdat), .i_mic_clock_pin(mclk),
    .i_converter_oversample_ratio(ratio), .i_sample_tick(tick), .i_left_volume_target(tgt_l),
    .i_right_volume_target(tgt_r), .o_instruction_mode(instr), .o_chain_select(chain), .o_aux_cond_a(aux_a),
    .o_aux_cond_b(aux_b), .o_frame_counter_reset_en(frame_en), .o_left_power_up(pwr_l), .o_right_power_up(pwr_r),
    .o_left_mic_enable(en_l), .o_right_mic_enable(en_r), .o_cic_default_unity(unity), .o_left_mic_bit(bit_l),
    .o_left_mic_valid(val_l), .o_right_mic_bit(bit_r), .o_right_mic_valid(val_r), .o_left_gain(gain_l),
    .o_right_gain(gain_r));
  adr_host u_host (.i_clock(i_clock), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(host_low));
  always #20 i_clock = !i_clock;
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.wr(a, d, ok);
    `CHK(ok, 1'h1)
    repeat (2) @(negedge i_clock);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    u_host.rd(a, d, ok);
    `CHK({ok, d}, {1'h1, e})
  endtask : r
  // Capture outcome is judged over a window long enough for the synchronisers.
  task automatic mod_edge(input logic m, input logic [1:0] ev, input logic [1:0] eb);
    logic [1:0] v;
    v = 2'h0;
    repeat (3) @(negedge i_clock);
    mod_clk = m;
    repeat (8) begin
      @(negedge i_clock);
      v = v | {val_l === 1'h1, val_r === 1'h1};
    end
    `CHK(v, ev)
    `CHK({bit_l, bit_r} & ev, eb)
  endtask : mod_edge
  task automatic tick_once();
    tick = 1'h1;
    @(negedge i_clock);
    tick = 1'h0;
    n_ticks++;
    @(negedge i_clock);
  endtask : tick_once
  ////////////////////////////////////////
  task automatic t_reset();
    `CHK({sda_o, instr, chain, frame_en}, {2'h0, 5'h01, 1'h1})
    `CHK({pwr_l, pwr_r, en_l, en_r}, 4'h0)
    r(8'h3C, 8'h00);
    r(8'h3D, 8'h01);
    r(8'h3E, 8'h00);
    r(8'h40, 8'h00);
    r(8'h50, 8'h00);
    r(8'h51, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_select();
    logic [4:0] codes [5] = '{5'h00, 5'h07, 5'h12, 5'h01, 5'h06};
    ratio = 8'h40;
    foreach (codes[k]) begin
      w(8'h3D, {3'h0, codes[k]});
      `CHK({instr, chain}, {codes[k] == 5'h00, codes[k]})
      `CHK(unity, codes[k] inside {[5'h01:5'h06]})
      r(8'h3D, {3'h0, codes[k]});
    end
    ratio = 8'h80;
    repeat (2) @(negedge i_clock);
    `CHK(unity, 1'h0)
    $display("t_select done");
  endtask : t_select
  task automatic t_instr();
    w(8'h3E, 8'h70);
    `CHK({aux_a, aux_b, frame_en}, 3'h6)
    r(8'h3E, 8'h70);
    w(8'h3E, 8'h20);
    `CHK({aux_a, aux_b, frame_en}, 3'h3)
    $display("t_instr done");
  endtask : t_instr
  task automatic t_mic();
    w(8'h50, 8'h02);
    r(8'h50, 8'h02);
    w(8'h51, 8'hDC);
    `CHK({pwr_l, pwr_r, en_l, en_r}, 4'hF)
    mdat = 1'h1;
    mod_edge(1'h1, 2'h1, 2'h0);
    mod_edge(1'h0, 2'h2, 2'h2);
    mdat = 1'h0;
    mclk = 1'h1;
    mod_edge(1'h1, 2'h1, 2'h1);
    mod_edge(1'h0, 2'h2, 2'h0);
    w(8'h51, 8'h5C);
    mod_edge(1'h1, 2'h1, 2'h1);
    mod_edge(1'h0, 2'h0, 2'h0);
    w(8'h51, 8'hD8);
    mod_edge(1'h1, 2'h0, 2'h0);
    mod_edge(1'h0, 2'h2, 2'h0);
    // Swapped source pins first, then swapped capture edges.
    w(8'h51, 8'hEC);
    mod_edge(1'h1, 2'h1, 2'h0);
    mod_edge(1'h0, 2'h2, 2'h2);
    w(8'h50, 8'h01);
    mdat = 1'h1;
    mclk = 1'h0;
    mod_edge(1'h1, 2'h2, 2'h0);
    mod_edge(1'h0, 2'h1, 2'h1);
    $display("t_mic done");
  endtask : t_mic
  task automatic t_step();
    logic [6:0] e;
    e = 7'h00;
    w(8'h51, 8'h00);
    tgt_l = 7'h03;
    tgt_r = 7'h03;
    repeat (5) begin
      tick_once();
      e = (e == 7'h03) ? e : e + 7'h01;
      `CHK({gain_l, gain_r}, {e, e})
    end
    w(8'h51, 8'h01);
    tgt_l = 7'h7E;
    tgt_r = 7'h7E;
    repeat (6) begin
      e = (n_ticks[0] && e != 7'h7E) ? e - 7'h01 : e;
      tick_once();
      `CHK({gain_l, gain_r}, {e, e})
    end
    w(8'h51, 8'h02);
    tgt_l = 7'h7B;
    tgt_r = 7'h05;
    repeat (2) @(negedge i_clock);
    `CHK({gain_l, gain_r}, {7'h7B, 7'h05})
    $display("t_step done");
  endtask : t_step
  ////////////////////////////////////////
  initial begin
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'h1;
    repeat (4) @(negedge i_clock);
    t_reset();
    t_select();
    t_instr();
    t_mic();
    t_step();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge i_clock);
    failures++;
    end_of_test();
  end
endmodule : adr_regs_tb_top
bind adr_regs adr_regs_sva u_sva (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_converter_oversample_ratio(i_converter_oversample_ratio), .i_sample_tick(i_sample_tick),
  .i_left_volume_target(i_left_volume_target), .o_instruction_mode(o_instruction_mode),
  .o_chain_select(o_chain_select), .o_aux_cond_a(o_aux_cond_a), .o_frame_counter_reset_en(o_frame_counter_reset_en),
  .o_left_power_up(o_left_power_up), .o_left_mic_enable(o_left_mic_enable), .o_left_mic_valid(o_left_mic_valid),
  .o_right_mic_valid(o_right_mic_valid), .o_cic_default_unity(o_cic_default_unity), .o_left_gain(o_left_gain));

// ===== adr_soft_step.sv
`include "adr_consts.svh"

module adr_soft_step
  import adr_pkg::*;
#(
  parameter int WIDTH = 7
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_target,
  input  wire logic             i_tick,
  input  wire logic [1:0]       i_mode,
  output logic      [WIDTH-1:0] o_gain
);

  adr_step_s q;
  adr_step_s n;
  logic      step_ok;

  // Code 01 moves only on every second sample tick.
  assign step_ok = i_tick & ((i_mode == `ADR_STEP_EVERY) | ((i_mode == `ADR_STEP_EVERY_OTHER) & q.half));

  always_comb begin
    n = q;
    if (i_tick) begin
      n.half = ~q.half;
    end
    // The reserved code behaves as a jump, so a stray write never freezes the gain.
    if ((i_mode == `ADR_STEP_JUMP) || (i_mode == 2'h3)) begin
      n.gain = i_target;
    end else if (step_ok && (q.gain != i_target)) begin
      if ($signed(q.gain) < $signed(i_target)) begin
        n.gain = q.gain + 7'h01;
      end else begin
        n.gain = q.gain - 7'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_gain = q.gain;

endmodule : adr_soft_step
